// File: fdcs_consts.vh
// register addresses, fuse field positions and defaults for the fuse/scaling block
// assumes inclusion by bare name from the design files
`ifndef FDCS_CONSTS_VH
`define FDCS_CONSTS_VH
`define FDCS_ADDR_W 7
`define FDCS_ADDR_FUSE 7'h07
`define FDCS_ADDR_MULT 7'h0b
`define FDCS_ADDR_OFFS 7'h0c
`define FDCS_MULT_RESET 8'h00
`define FDCS_MULT_MIN_OK 8'h20
`define FDCS_FULL_SCALE 9'h100
`define FDCS_FUSE_TBL_BIT 7
`define FDCS_FUSE_BBM_BIT 6
`define FDCS_FUSE_S2_BIT 5
`define FDCS_FUSE_TRIM_HI 4
`define FDCS_TBL_FUSE0 2'h2
`define FDCS_TBL_FUSE1 2'h1
`define FDCS_BBM_FUSE0 4'h4
`define FDCS_BBM_FUSE1 4'h2
`define FDCS_S2_FUSE0 4'h6
`define FDCS_S2_FUSE1 4'hc
`define FDCS_CLK_PERIOD_NS 4
`define FDCS_FUSE_PROG_NS 100
`define FDCS_FUSE_PROG_CYC 8'h19
`endif

// File: fdcs_fuse_array.v
// one-time-programmable fuse byte modelled in flip-flops
// assumes prog_req is a one-cycle pulse; fuse state survives only while powered
`timescale 1ns/1ps
`include "fdcs_consts.vh"
module fdcs_fuse_array (
	input wire clk,
	input wire rst_b,
	input wire prog_req,
	input wire [2:0] prog_bit,
	output wire prog_busy,
	output wire [7:0] fuse_q
);
	reg [7:0] fuse_ff;
	reg [7:0] cnt_ff;
	reg [2:0] bit_ff;
	reg [7:0] nxt_cnt;
	reg [7:0] nxt_fuse;
	assign fuse_q = fuse_ff;
	assign prog_busy = (cnt_ff != 8'h00);
	// only sets a bit, never clears
	always @* begin
		nxt_cnt = cnt_ff;
		nxt_fuse = fuse_ff;
		if (cnt_ff != 8'h00) begin
			nxt_cnt = cnt_ff - 8'h01;
			if (cnt_ff == 8'h01)
				nxt_fuse = fuse_ff | (8'h01 << bit_ff);
		end else if (prog_req) begin
			nxt_cnt = `FDCS_FUSE_PROG_CYC;
		end
	end
	// fuse contents are not touched by the logic reset
	always @(posedge clk) begin
		fuse_ff <= nxt_fuse;
	end
	initial fuse_ff = 8'h00;
	always @(posedge clk) begin
		if (!rst_b) begin
			cnt_ff <= 8'h00;
			bit_ff <= 3'h0;
		end else begin
			cnt_ff <= nxt_cnt;
			if (prog_req && cnt_ff == 8'h00)
				bit_ff <= prog_bit;
		end
	end
endmodule // fdcs_fuse_array

// File: fdcs_fuse_defaults.v
// fuse defaults, global current multiplier and sense offset readback
// assumes a simple synchronous register port from the serial interface block
//
// Notes on behaviour
// - global multiplier multiplies into every phase current target.
// - multiplier zero means full scale, 256/256.
// - values 32 to 255 scale maximum current by value/256.
// - multiplier also scales chopper hysteresis.
// - offset readback: phase A in bits 15:8, phase B in 7:0, signed.
// - fuse byte supplies power-up defaults when leaving reset.
// - unprogrammed fuse bits read zero.
// - fuse bits can only go from zero to one.
// - fuse bit 7 picks blank time default %10 or %01.
// - fuse bit 6 picks dead time clock count 4 or 2.
// - fuse bit 5 picks both short levels 6 or 12.
// - fuse bits 4:0 give oscillator trim default, 0 lowest.
// - dead time count 0 to 15 in core clock cycles.
`timescale 1ns/1ps
`include "fdcs_consts.vh"
module fdcs_fuse_defaults (
	input wire clk,
	input wire rst_b,
	input wire reg_wr,
	input wire reg_rd,
	input wire [6:0] reg_addr,
	input wire [31:0] reg_wdata,
	output wire [31:0] reg_rdata,
	output wire reg_ready,
	input wire fuse_prog_req,
	input wire [2:0] fuse_prog_bit,
	output wire fuse_prog_busy,
	input wire [7:0] offset_phase_a,
	input wire [7:0] offset_phase_b,
	input wire [7:0] coil_current_a,
	input wire [7:0] coil_current_b,
	input wire [7:0] hysteresis_in,
	output wire [15:0] scaled_current_a,
	output wire [15:0] scaled_current_b,
	output wire [15:0] scaled_hysteresis,
	output wire [1:0] blank_time_select,
	output wire [3:0] deadtime_clock_count,
	output wire [3:0] short_to_ground_level,
	output wire [3:0] short_to_supply_level,
	output wire [4:0] oscillator_trim,
	output wire multiplier_not_allowed
);
	localparam ST_LOAD = 2'b01;
	localparam ST_RUN = 2'b10;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [7:0] mult_ff;
	reg [7:0] nxt_mult;
	reg [1:0] blank_ff;
	reg [1:0] nxt_blank;
	reg [3:0] dead_ff;
	reg [3:0] nxt_dead;
	reg [3:0] s2g_ff;
	reg [3:0] nxt_s2g;
	reg [3:0] s2vs_ff;
	reg [3:0] nxt_s2vs;
	reg [4:0] trim_ff;
	reg [4:0] nxt_trim;
	reg [31:0] rdata_ff;
	reg [31:0] nxt_rdata;
	reg [15:0] cur_a_ff;
	reg [15:0] nxt_cur_a;
	reg [15:0] cur_b_ff;
	reg [15:0] nxt_cur_b;
	reg [15:0] hyst_ff;
	reg [15:0] nxt_hyst;
	wire [7:0] fuse_q;
	wire running;
	wire load_now;
	wire prog_ok;
	wire wr_mult;
	wire rd_fuse;
	wire rd_offs;
	// register index match
	function addr_hit;
		input [6:0] a;
		input [6:0] target;
		begin
			addr_hit = (a == target);
		end
	endfunction
	// fuse bit picks one of two 4-bit defaults
	function [3:0] pick4;
		input sel;
		input [3:0] when0;
		input [3:0] when1;
		begin
			pick4 = sel ? when1 : when0;
		end
	endfunction
	// zero maps to 256
	function [8:0] eff_mult;
		input [7:0] m;
		begin
			eff_mult = (m == 8'h00) ? `FDCS_FULL_SCALE : {1'b0, m};
		end
	endfunction
	// value times multiplier over 256
	function [15:0] scale;
		input [7:0] v;
		input [7:0] m;
		reg [16:0] p;
		begin
			p = {9'h000, v} * {8'h00, eff_mult(m)};
			scale = {8'h00, p[15:8]} | {7'h00, p[16], 8'h00};
		end
	endfunction
	assign running = (state_ff == ST_RUN);
	assign load_now = (state_ff == ST_LOAD);
	assign prog_ok = fuse_prog_req & running;
	assign wr_mult = running & reg_wr & addr_hit(reg_addr, `FDCS_ADDR_MULT);
	assign rd_fuse = addr_hit(reg_addr, `FDCS_ADDR_FUSE);
	assign rd_offs = addr_hit(reg_addr, `FDCS_ADDR_OFFS);
	assign reg_ready = running;
	assign reg_rdata = rdata_ff;
	assign scaled_current_a = cur_a_ff;
	assign scaled_current_b = cur_b_ff;
	assign scaled_hysteresis = hyst_ff;
	assign blank_time_select = blank_ff;
	assign deadtime_clock_count = dead_ff;
	assign short_to_ground_level = s2g_ff;
	assign short_to_supply_level = s2vs_ff;
	assign oscillator_trim = trim_ff;
	assign multiplier_not_allowed = (mult_ff != 8'h00) && (mult_ff < `FDCS_MULT_MIN_OK);
	fdcs_fuse_array u_fuse (
		.clk(clk),
		.rst_b(rst_b),
		.prog_req(prog_ok),
		.prog_bit(fuse_prog_bit),
		.prog_busy(fuse_prog_busy),
		.fuse_q(fuse_q)
	);
	// load once after reset, then serve accesses
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_LOAD: begin
				nxt_state = ST_RUN;
			end
			ST_RUN: begin
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_LOAD;
			end
		endcase
	end
	always @(posedge clk) begin
		if (!rst_b) begin
			state_ff <= ST_LOAD;
		end else begin
			state_ff <= nxt_state;
		end
	end
	// fuse defaults sampled in the load state only
	always @* begin
		nxt_blank = blank_ff;
		nxt_dead = dead_ff;
		nxt_s2g = s2g_ff;
		nxt_s2vs = s2vs_ff;
		nxt_trim = trim_ff;
		if (load_now) begin
			nxt_blank = fuse_q[`FDCS_FUSE_TBL_BIT] ? `FDCS_TBL_FUSE1 : `FDCS_TBL_FUSE0;
			nxt_dead = pick4(fuse_q[`FDCS_FUSE_BBM_BIT], `FDCS_BBM_FUSE0, `FDCS_BBM_FUSE1);
			nxt_s2g = pick4(fuse_q[`FDCS_FUSE_S2_BIT], `FDCS_S2_FUSE0, `FDCS_S2_FUSE1);
			nxt_s2vs = pick4(fuse_q[`FDCS_FUSE_S2_BIT], `FDCS_S2_FUSE0, `FDCS_S2_FUSE1);
			nxt_trim = fuse_q[`FDCS_FUSE_TRIM_HI:0];
		end
	end
	always @(posedge clk) begin
		if (!rst_b) begin
			blank_ff <= 2'h0;
			dead_ff <= 4'h0;
			s2g_ff <= 4'h0;
			s2vs_ff <= 4'h0;
			trim_ff <= 5'h00;
		end else begin
			blank_ff <= nxt_blank;
			dead_ff <= nxt_dead;
			s2g_ff <= nxt_s2g;
			s2vs_ff <= nxt_s2vs;
			trim_ff <= nxt_trim;
		end
	end
	// write-only multiplier; 1 to 31 stored and flagged
	always @* begin
		nxt_mult = mult_ff;
		if (wr_mult) begin
			nxt_mult = reg_wdata[7:0];
		end
	end
	always @(posedge clk) begin
		if (!rst_b) begin
			mult_ff <= `FDCS_MULT_RESET;
		end else begin
			mult_ff <= nxt_mult;
		end
	end
	// read data holds until the next read
	always @* begin
		nxt_rdata = rdata_ff;
		if (running && reg_rd) begin
			if (rd_fuse) begin
				nxt_rdata = {24'h00_0000, fuse_q};
			end else if (rd_offs) begin
				nxt_rdata = {16'h0000, offset_phase_a, offset_phase_b};
			end else begin
				nxt_rdata = 32'h0000_0000;
			end
		end
	end
	always @(posedge clk) begin
		if (!rst_b) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end
	// all three targets share one multiplier
	always @* begin
		nxt_cur_a = scale(coil_current_a, mult_ff);
		nxt_cur_b = scale(coil_current_b, mult_ff);
		nxt_hyst = scale(hysteresis_in, mult_ff);
	end
	always @(posedge clk) begin
		if (!rst_b) begin
			cur_a_ff <= 16'h0000;
			cur_b_ff <= 16'h0000;
			hyst_ff <= 16'h0000;
		end else begin
			cur_a_ff <= nxt_cur_a;
			cur_b_ff <= nxt_cur_b;
			hyst_ff <= nxt_hyst;
		end
	end
endmodule // fdcs_fuse_defaults

// File: fdcs_monitor.sv
// checker: readback, fuse defaults, current scaling
// bound to fdcs_fuse_defaults from the bench file
`timescale 1ns/1ps
module fdcs_monitor (
	input wire clk,
	input wire rst_b,
	input wire reg_wr,
	input wire reg_rd,
	input wire [6:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	input wire reg_ready,
	input wire [7:0] offset_phase_a,
	input wire [7:0] offset_phase_b,
	input wire [7:0] coil_current_a,
	input wire [7:0] hysteresis_in,
	input wire [15:0] scaled_current_a,
	input wire [15:0] scaled_hysteresis,
	input wire [1:0] blank_time_select,
	input wire [3:0] deadtime_clock_count,
	input wire [3:0] short_to_ground_level,
	input wire [3:0] short_to_supply_level
);
logic [7:0] m_ff;
wire [8:0] eff = m_ff == 8'h00 ? 9'h100 : {1'b0, m_ff};
always @(posedge clk) begin
	if (!rst_b) m_ff <= 8'h00;
	else if (reg_wr && reg_ready && reg_addr == 7'h0b) m_ff <= reg_wdata[7:0];
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
offs_read_a: assert property (
	reg_rd && reg_ready && reg_addr == 7'h0c |=> reg_rdata[15:0] == {$past(offset_phase_a), $past(offset_phase_b)})
	else $error("offset read wrong");
ready_after_a: assert property (rst_b [*3] |-> reg_ready) else $error("not ready");
ready_hold_a: assert property (reg_ready |=> reg_ready) else $error("ready dropped");
blank_dflt_a: assert property (
	reg_ready |-> blank_time_select inside {2'h1, 2'h2}) else $error("bad blank time");
dead_dflt_a: assert property (
	reg_ready |-> deadtime_clock_count inside {4'h2, 4'h4}) else $error("bad dead time");
short_dflt_a: assert property (
	reg_ready |-> short_to_ground_level == short_to_supply_level && short_to_supply_level inside {4'h6, 4'hc})
	else $error("bad short level");
scale_cur_a: assert property (
	$past(rst_b) |-> scaled_current_a == ({8'h00, $past(coil_current_a)} * {7'h00, $past(eff)}) >> 8)
	else $error("bad scaled current");
scale_hyst_a: assert property (
	$past(rst_b) |-> scaled_hysteresis == ({8'h00, $past(hysteresis_in)} * {7'h00, $past(eff)}) >> 8)
	else $error("bad scaled hysteresis");
endmodule // fdcs_monitor

// File: fdcs_fuse_defaults_tb.sv
// bench for fdcs_fuse_defaults
// drives every port itself; checker bound at the foot
`timescale 1ns/1ps
module fdcs_fuse_defaults_tb;
logic clk = 0, rst_b = 0, wr = 0, rd = 0, preq = 0;
logic [6:0] ad = 0;
logic [31:0] wd = 0, q[$];
logic [2:0] pb = 0;
logic [7:0] oa = 0, ob = 0, ca = 0, hy = 0, f = 0, m;
logic [7:0] mt[5] = '{8'h00, 8'h1f, 8'h20, 8'h80, 8'hff};
int fail_count = 0, samples_checked = 0, cyc = 0, n = 0;
always #2 clk = ~clk;
fdcs_fuse_defaults u_dut (.clk(clk), .rst_b(rst_b), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd),
	.reg_rdata(), .reg_ready(), .fuse_prog_req(preq), .fuse_prog_bit(pb), .fuse_prog_busy(), .offset_phase_a(oa),
	.offset_phase_b(ob), .coil_current_a(ca), .coil_current_b(~ca), .hysteresis_in(hy), .scaled_current_a(),
	.scaled_current_b(), .scaled_hysteresis(), .blank_time_select(), .deadtime_clock_count(),
	.short_to_ground_level(), .short_to_supply_level(), .oscillator_trim(), .multiplier_not_allowed());
task chk(input logic [31:0] s, e);
	samples_checked++;
	if (s !== e) begin
		fail_count++;
		$display("Error %0t: got %h want %h", $time, s, e);
	end
endtask
task tally_and_finish;
	$display("checked %0d failed %0d", samples_checked, fail_count);
	if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
task step;
	@(posedge clk);
	#1;
endtask
task acc(input logic w, input logic [6:0] a, input logic [31:0] d);
	wr = w;
	rd = !w;
	ad = a;
	wd = d;
	if (!w) q.push_back(d);
	step;
endtask
task idle;
	wr = 0;
	rd = 0;
	step;
endtask
task rst;
	rst_b = 0;
	repeat (2) step;
	chk(u_dut.reg_ready, 0);
	rst_b = 1;
	step;
	chk(u_dut.reg_ready, 1);
	repeat (2) step;
endtask
task dflt;
	chk(u_dut.blank_time_select, f[7] ? 2'h1 : 2'h2);
	chk(u_dut.deadtime_clock_count, f[6] ? 4'h2 : 4'h4);
	chk({u_dut.short_to_ground_level, u_dut.short_to_supply_level}, f[5] ? 8'hcc : 8'h66);
	chk(u_dut.oscillator_trim, f[4:0]);
	acc(0, 7'h07, f);
	idle;
endtask
always @(posedge clk) begin
	cyc++;
	if (cyc == 4000) begin
		fail_count++;
		tally_and_finish;
	end else if (rst_b && rd && u_dut.reg_ready && q.size() > 0) begin
		#1 chk(u_dut.reg_rdata, q.pop_front());
	end
end
initial begin
	void'($urandom(32'h1376));
	rst;
	dflt;
	// first two stand in for factory trim, then user bits only
	for (int k = 0; k < 6; k++) begin
		pb = (k < 2) ? 3'($urandom % 5) : 3'(5 + $urandom % 3);
		preq = 1;
		step;
		preq = 0;
		f[pb] = 1'b1;
		n = 0;
		while (u_dut.fuse_prog_busy && n < 50) begin
			step;
			n++;
		end
		chk(n, 25);
	end
	acc(0, 7'h07, f);
	idle;
	rst;
	dflt;
	oa = $urandom;
	ob = $urandom;
	acc(0, 7'h0c, {16'h0000, oa, ob});
	acc(0, 7'h0b, 0);
	acc(0, 7'h5a, 0);
	for (int i = 0; i < 7; i++) begin
		m = (i < 5) ? mt[i] : 8'h81 + 8'($urandom % 127);
		ca = $urandom;
		hy = $urandom;
		acc(1, 7'h0b, {24'h00_0000, m});
		idle;
		step;
		chk(u_dut.scaled_current_a, ({8'h00, ca} * (m != 8'h00 ? {1'b0, m} : 9'h100)) >> 8);
		chk(u_dut.scaled_current_b, ({8'h00, ~ca} * (m != 8'h00 ? {1'b0, m} : 9'h100)) >> 8);
		chk(u_dut.multiplier_not_allowed, m > 8'h00 && m < 8'h20);
	end
	chk(q.size(), 0);
	tally_and_finish;
end
endmodule // fdcs_fuse_defaults_tb
bind fdcs_fuse_defaults fdcs_monitor u_mon (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
	.reg_ready, .offset_phase_a, .offset_phase_b, .coil_current_a, .hysteresis_in, .scaled_current_a,
	.scaled_hysteresis, .blank_time_select, .deadtime_clock_count, .short_to_ground_level, .short_to_supply_level);
